// *** src/ssm_defs.svh ***
// register map, field positions, reset values, bit counts, buffer depth and bus responses
`ifndef SSM_DEFS_SVH
`define SSM_DEFS_SVH
`define SSM_OFF_TXSTAT   8'h00
`define SSM_OFF_RXSTAT   8'h04
`define SSM_OFF_RXDATA   8'h08
`define SSM_OFF_TXDATA   8'h0C
`define SSM_OFF_BAUDCTL  8'h10
`define SSM_OFF_DIVLO    8'h14
`define SSM_OFF_DIVHI    8'h18
`define SSM_OFF_IRQ      8'h1C
`define SSM_TX_MASTER    7
`define SSM_TX_NINE      6
`define SSM_TX_EN        5
`define SSM_TX_SYNC      4
`define SSM_TX_HSPEED    2
`define SSM_TX_EMPTY     1
`define SSM_TX_NINTH     0
`define SSM_RX_PORTEN    7
`define SSM_RX_NINE      6
`define SSM_RX_SINGLE    5
`define SSM_RX_CONT      4
`define SSM_RX_OVERRUN   1
`define SSM_RX_NINTH     0
`define SSM_BC_POL       4
`define SSM_BC_WIDE      3
`define SSM_IRQ_RXEN     0
`define SSM_IRQ_TRANSMIT_ENABLE     1
`define SSM_IRQ_PERIPH   2
`define SSM_IRQ_GLOBAL   3
`define SSM_IRQ_RXFLAG   4
`define SSM_IRQ_TXFLAG   5
`define SSM_RST_BYTE     8'h00
`define SSM_BITS_NARROW  4'h8
`define SSM_BITS_WIDE    4'h9
`define SSM_FIFO_DEPTH   2'h2
`define SSM_RESP_OKAY    2'h0
`define SSM_RESP_SLVERR  2'h2
`endif

// *** src/ssm_pkg.sv ***
// types shared by the synchronous serial block
package ssm_pkg;
  typedef enum logic [2:0] {
    SSM_OFF,
    SSM_MASTER_RX,
    SSM_MASTER_IDLE,
    SSM_SLAVE_RX,
    SSM_SLAVE_TX,
    SSM_SLAVE_IDLE
  } ssm_mode_t;
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } ssm_char_t;
  typedef struct packed {
    logic o;
    logic oe;
  } ssm_pin_t;
endpackage

// *** src/ssm_top.sv ***
// synchronous serial port, master receive and slave transmit/receive
`timescale 1ns/1ps
`include "ssm_defs.svh"
module ssm_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cpu_sleep,
  input  wire logic        clock_pin_i,
  output logic             clock_pin_o,
  output logic             clock_pin_oe,
  input  wire logic        data_pin_i,
  output logic             data_pin_o,
  output logic             data_pin_oe,
  output logic             processor_wake,
  output logic             irq_vector_req
);
  logic              clock_source_master_reg;
  logic              nine_bit_transmit_reg;
  logic              transmit_enable_reg;
  logic              sync_mode_reg;
  logic              high_speed_baud_reg;
  logic              transmit_ninth_bit_reg;
  logic              port_enable_reg;
  logic              nine_bit_receive_reg;
  logic              single_receive_enable_reg;
  logic              continuous_receive_enable_reg;
  logic              overrun_error_reg;
  logic              clock_polarity_invert_reg;
  logic              wide_baud_divisor_reg;
  logic [7:0]        baud_divisor_low_reg;
  logic [7:0]        baud_divisor_high_reg;
  logic              receive_irq_enable_reg;
  logic              transmit_irq_enable_reg;
  logic              peripheral_irq_enable_reg;
  logic              global_irq_enable_reg;
  logic              ck_meta_reg;
  logic              ck_sync_reg;
  logic              ck_prev_reg;
  logic              dt_meta_reg;
  logic              dt_sync_reg;
  logic [7:0]        aw_addr_reg;
  logic              aw_full_reg;
  logic [31:0]       w_data_reg;
  logic              w_byte0_reg;
  logic              w_full_reg;
  logic              awready_reg;
  logic              wready_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              arready_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;
  logic [16:0]       baud_cnt_reg;
  logic              mphase_reg;
  logic              mclk_reg;
  logic [3:0]        rx_cnt_reg;
  logic [8:0]        receive_shift_reg;
  ssm_pkg::ssm_char_t fifo_reg [0:1];
  logic              rd_ptr_reg;
  logic [1:0]        fifo_cnt_reg;
  logic [8:0]        transmit_shift_reg;
  logic [3:0]        tx_cnt_reg;
  logic              tsr_busy_reg;
  logic [7:0]        transmit_data_reg;
  logic              txbuf_full_reg;
  ssm_pkg::ssm_pin_t data_pin_reg;
  ssm_pkg::ssm_pin_t clock_pin_reg;
  logic              wake_reg;
  logic              vector_reg;
  ssm_pkg::ssm_mode_t mode;
  logic              port_rst;
  logic              ck_lead;
  logic              ck_trail;
  logic [15:0]       divisor;
  logic              baud_tick;
  logic              rx_sample;
  logic              rx_done;
  logic [3:0]        rx_bits;
  logic [3:0]        tx_bits;
  logic [8:0]        rsr_next;
  ssm_pkg::ssm_char_t rx_char;
  ssm_pkg::ssm_char_t fifo_head;
  logic              push;
  logic              pop;
  logic              overflow;
  logic              tx_load;
  logic              receive_flag;
  logic              transmit_flag;
  logic              wr_fire;
  logic              wr_map;
  logic [7:0]        wbyte;
  logic              rd_fire;
  logic              cont_clear_evt;
  logic [7:0]        rd_byte;
  logic              rd_map;

  // mode decode
  always_comb
  begin
    if (!port_enable_reg || !sync_mode_reg)
      mode = ssm_pkg::SSM_OFF;
    else if (clock_source_master_reg)
      mode = (single_receive_enable_reg || continuous_receive_enable_reg)
           ? ssm_pkg::SSM_MASTER_RX : ssm_pkg::SSM_MASTER_IDLE;
    else if (continuous_receive_enable_reg || single_receive_enable_reg)
      mode = ssm_pkg::SSM_SLAVE_RX;
    else if (transmit_enable_reg)
      mode = ssm_pkg::SSM_SLAVE_TX;
    else
      mode = ssm_pkg::SSM_SLAVE_IDLE;
  end

  assign port_rst  = !port_enable_reg;
  // leading edge leaves the idle level
  assign ck_lead   = clock_polarity_invert_reg
                   ? (ck_prev_reg && !ck_sync_reg)
                   : (!ck_prev_reg && ck_sync_reg);
  assign ck_trail  = clock_polarity_invert_reg
                   ? (!ck_prev_reg && ck_sync_reg)
                   : (ck_prev_reg && !ck_sync_reg);
  assign divisor   = wide_baud_divisor_reg
                   ? {baud_divisor_high_reg, baud_divisor_low_reg}
                   : {8'h00, baud_divisor_low_reg};
  // master stalls in sleep, it needs the system clock
  assign baud_tick = (mode == ssm_pkg::SSM_MASTER_RX) && !cpu_sleep &&
                     !overrun_error_reg &&
                     (baud_cnt_reg == {divisor, 1'b1});
  assign rx_bits   = nine_bit_receive_reg ? `SSM_BITS_WIDE
                                          : `SSM_BITS_NARROW;
  assign tx_bits   = nine_bit_transmit_reg ? `SSM_BITS_WIDE
                                           : `SSM_BITS_NARROW;
  assign rx_sample = !overrun_error_reg &&
                     (((mode == ssm_pkg::SSM_SLAVE_RX) && ck_trail) ||
                      (baud_tick && mphase_reg));
  assign rx_done   = rx_sample && (rx_cnt_reg == rx_bits - 4'h1);
  assign rsr_next  = {dt_sync_reg, receive_shift_reg[8:1]};
  assign rx_char   = nine_bit_receive_reg ? rsr_next
                                          : {1'b0, rsr_next[8:1]};
  assign fifo_head = fifo_reg[rd_ptr_reg];
  assign push      = rx_done && (fifo_cnt_reg != `SSM_FIFO_DEPTH);
  assign overflow  = rx_done && (fifo_cnt_reg == `SSM_FIFO_DEPTH);
  assign tx_load   = (mode == ssm_pkg::SSM_SLAVE_TX) &&
                     txbuf_full_reg && !tsr_busy_reg;
  assign receive_flag  = (fifo_cnt_reg != 2'h0);
  assign transmit_flag = !txbuf_full_reg;

  assign wr_fire   = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wbyte     = w_data_reg[7:0];
  assign rd_fire   = s_axi_arvalid && arready_reg;
  assign pop       = rd_fire && (s_axi_araddr == `SSM_OFF_RXDATA) &&
                     receive_flag;
  assign cont_clear_evt = wr_fire && w_byte0_reg &&
                          (aw_addr_reg == `SSM_OFF_RXSTAT) &&
                          continuous_receive_enable_reg &&
                          !wbyte[`SSM_RX_CONT];

  always_comb
  begin
    wr_map = 1'b1;
    case (aw_addr_reg)
      `SSM_OFF_TXSTAT, `SSM_OFF_RXSTAT, `SSM_OFF_RXDATA,
      `SSM_OFF_TXDATA, `SSM_OFF_BAUDCTL, `SSM_OFF_DIVLO,
      `SSM_OFF_DIVHI, `SSM_OFF_IRQ: wr_map = 1'b1;
      default: wr_map = 1'b0;
    endcase
  end

  // read mux; unused positions are zero
  always_comb
  begin
    rd_map  = 1'b1;
    rd_byte = `SSM_RST_BYTE;
    case (s_axi_araddr)
      `SSM_OFF_TXSTAT: rd_byte = {clock_source_master_reg,
        nine_bit_transmit_reg, transmit_enable_reg, sync_mode_reg,
        1'b0, high_speed_baud_reg, !tsr_busy_reg,
        transmit_ninth_bit_reg};
      `SSM_OFF_RXSTAT: rd_byte = {port_enable_reg, nine_bit_receive_reg,
        single_receive_enable_reg, continuous_receive_enable_reg,
        2'b00, overrun_error_reg, fifo_head.ninth};
      `SSM_OFF_RXDATA: rd_byte = fifo_head.data;
      `SSM_OFF_TXDATA: rd_byte = `SSM_RST_BYTE;
      `SSM_OFF_BAUDCTL: rd_byte = {3'b000, clock_polarity_invert_reg,
        wide_baud_divisor_reg, 3'b000};
      `SSM_OFF_DIVLO: rd_byte = baud_divisor_low_reg;
      `SSM_OFF_DIVHI: rd_byte = baud_divisor_high_reg;
      `SSM_OFF_IRQ: rd_byte = {2'b00, transmit_flag, receive_flag,
        global_irq_enable_reg, peripheral_irq_enable_reg,
        transmit_irq_enable_reg, receive_irq_enable_reg};
      default: rd_map = 1'b0;
    endcase
  end

  // pin synchronisers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ck_meta_reg <= 1'b0;
      ck_sync_reg <= 1'b0;
      ck_prev_reg <= 1'b0;
      dt_meta_reg <= 1'b0;
      dt_sync_reg <= 1'b0;
    end
    else
    begin
      ck_meta_reg <= clock_pin_i;
      ck_sync_reg <= ck_meta_reg;
      ck_prev_reg <= ck_sync_reg;
      dt_meta_reg <= data_pin_i;
      dt_sync_reg <= dt_meta_reg;
    end
  end

  // bus write and read channels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_addr_reg <= 8'h00;
      aw_full_reg <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_byte0_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `SSM_RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= `SSM_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && awready_reg)
      begin
        aw_addr_reg <= s_axi_awaddr;
        aw_full_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid && wready_reg)
      begin
        w_data_reg  <= s_axi_wdata;
        w_byte0_reg <= s_axi_wstrb[0];
        w_full_reg  <= 1'b1;
        wready_reg  <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_map ? `SSM_RESP_OKAY : `SSM_RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready)
      begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
      if (rd_fire)
      begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rdata_reg   <= {24'h000000, rd_byte};
        rresp_reg   <= rd_map ? `SSM_RESP_OKAY : `SSM_RESP_SLVERR;
      end
      else if (rvalid_reg && s_axi_rready)
      begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // control registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clock_source_master_reg       <= 1'b0;
      nine_bit_transmit_reg         <= 1'b0;
      transmit_enable_reg           <= 1'b0;
      sync_mode_reg                 <= 1'b0;
      high_speed_baud_reg           <= 1'b0;
      transmit_ninth_bit_reg        <= 1'b0;
      port_enable_reg               <= 1'b0;
      nine_bit_receive_reg          <= 1'b0;
      single_receive_enable_reg     <= 1'b0;
      continuous_receive_enable_reg <= 1'b0;
      clock_polarity_invert_reg     <= 1'b0;
      wide_baud_divisor_reg         <= 1'b0;
      baud_divisor_low_reg          <= `SSM_RST_BYTE;
      baud_divisor_high_reg         <= `SSM_RST_BYTE;
      receive_irq_enable_reg        <= 1'b0;
      transmit_irq_enable_reg       <= 1'b0;
      peripheral_irq_enable_reg     <= 1'b0;
      global_irq_enable_reg         <= 1'b0;
    end
    else
    begin
      // one character done in master receive, single receive drops itself
      if (rx_done && (mode == ssm_pkg::SSM_MASTER_RX))
        single_receive_enable_reg <= 1'b0;
      if (wr_fire && w_byte0_reg)
      begin
        case (aw_addr_reg)
          `SSM_OFF_TXSTAT:
          begin
            clock_source_master_reg <= wbyte[`SSM_TX_MASTER];
            nine_bit_transmit_reg   <= wbyte[`SSM_TX_NINE];
            transmit_enable_reg     <= wbyte[`SSM_TX_EN];
            sync_mode_reg           <= wbyte[`SSM_TX_SYNC];
            high_speed_baud_reg     <= wbyte[`SSM_TX_HSPEED];
            transmit_ninth_bit_reg  <= wbyte[`SSM_TX_NINTH];
          end
          `SSM_OFF_RXSTAT:
          begin
            port_enable_reg               <= wbyte[`SSM_RX_PORTEN];
            nine_bit_receive_reg          <= wbyte[`SSM_RX_NINE];
            single_receive_enable_reg     <= wbyte[`SSM_RX_SINGLE];
            continuous_receive_enable_reg <= wbyte[`SSM_RX_CONT];
          end
          `SSM_OFF_BAUDCTL:
          begin
            clock_polarity_invert_reg <= wbyte[`SSM_BC_POL];
            wide_baud_divisor_reg     <= wbyte[`SSM_BC_WIDE];
          end
          `SSM_OFF_DIVLO: baud_divisor_low_reg  <= wbyte;
          `SSM_OFF_DIVHI: baud_divisor_high_reg <= wbyte;
          `SSM_OFF_IRQ:
          begin
            receive_irq_enable_reg    <= wbyte[`SSM_IRQ_RXEN];
            transmit_irq_enable_reg   <= wbyte[`SSM_IRQ_TRANSMIT_ENABLE];
            peripheral_irq_enable_reg <= wbyte[`SSM_IRQ_PERIPH];
            global_irq_enable_reg     <= wbyte[`SSM_IRQ_GLOBAL];
          end
          default: ;
        endcase
      end
    end
  end

  // master bit clock from the divisor
  always_ff @(posedge aclk)
  begin
    if (!aresetn || mode != ssm_pkg::SSM_MASTER_RX || overrun_error_reg)
    begin
      // clock stops at once; partial character is dropped below unless the new mode is SSM_SLAVE_RX
      baud_cnt_reg <= 17'h00000;
      mphase_reg   <= 1'b0;
      mclk_reg     <= clock_polarity_invert_reg;
    end
    else if (cpu_sleep)
      baud_cnt_reg <= baud_cnt_reg;
    else if (baud_tick)
    begin
      baud_cnt_reg <= 17'h00000;
      mphase_reg   <= !mphase_reg;
      mclk_reg     <= !mclk_reg;
    end
    else
      baud_cnt_reg <= baud_cnt_reg + 17'h00001;
  end

  // receive shifter and two-entry buffer
  always_ff @(posedge aclk)
  begin
    if (!aresetn || port_rst)
    begin
      rx_cnt_reg        <= 4'h0;
      receive_shift_reg <= 9'h000;
      fifo_reg[0]       <= 9'h000;
      fifo_reg[1]       <= 9'h000;
      rd_ptr_reg        <= 1'b0;
      fifo_cnt_reg      <= 2'h0;
      overrun_error_reg <= 1'b0;
    end
    else
    begin
      if (mode != ssm_pkg::SSM_MASTER_RX && mode != ssm_pkg::SSM_SLAVE_RX)
        rx_cnt_reg <= 4'h0;
      else if (rx_done)
        rx_cnt_reg <= 4'h0;
      else if (rx_sample)
      begin
        rx_cnt_reg        <= rx_cnt_reg + 4'h1;
        receive_shift_reg <= rsr_next;
      end
      if (push)
        fifo_reg[rd_ptr_reg ^ fifo_cnt_reg[0]] <= rx_char;
      if (pop)
        rd_ptr_reg <= !rd_ptr_reg;
      fifo_cnt_reg <= fifo_cnt_reg + {1'b0, push} - {1'b0, pop};
      // a new overrun wins over a clear in the same cycle
      if (overflow)
        overrun_error_reg <= 1'b1;
      else if (cont_clear_evt ||
               (pop && !continuous_receive_enable_reg))
        overrun_error_reg <= 1'b0;
    end
  end

  // slave transmit: buffer plus shifter on the link clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn || port_rst)
    begin
      transmit_data_reg  <= `SSM_RST_BYTE;
      txbuf_full_reg     <= 1'b0;
      transmit_shift_reg <= 9'h000;
      tx_cnt_reg         <= 4'h0;
      tsr_busy_reg       <= 1'b0;
      data_pin_reg       <= 2'b00;
    end
    else
    begin
      data_pin_reg.oe <= (mode == ssm_pkg::SSM_SLAVE_TX);
      if (tx_load)
      begin
        transmit_shift_reg <= {transmit_ninth_bit_reg,
                               transmit_data_reg};
        tsr_busy_reg       <= 1'b1;
        tx_cnt_reg         <= 4'h0;
        data_pin_reg.o     <= transmit_data_reg[0];
        txbuf_full_reg     <= 1'b0;
      end
      else if (mode != ssm_pkg::SSM_SLAVE_TX)
        tsr_busy_reg <= 1'b0;
      else if (tsr_busy_reg && ck_lead)
        data_pin_reg.o <= transmit_shift_reg[0];
      else if (tsr_busy_reg && ck_trail)
      begin
        transmit_shift_reg <= {1'b0, transmit_shift_reg[8:1]};
        tx_cnt_reg         <= tx_cnt_reg + 4'h1;
        if (tx_cnt_reg == tx_bits - 4'h1)
          tsr_busy_reg <= 1'b0;
      end
      // a write lands after any load in the same cycle
      if (wr_fire && w_byte0_reg && aw_addr_reg == `SSM_OFF_TXDATA)
      begin
        transmit_data_reg <= wbyte;
        txbuf_full_reg    <= 1'b1;
      end
    end
  end

  // clock pin drive, wake and vector requests
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clock_pin_reg <= 2'b00;
      wake_reg      <= 1'b0;
      vector_reg    <= 1'b0;
    end
    else
    begin
      clock_pin_reg.o  <= mclk_reg;
      clock_pin_reg.oe <= (mode == ssm_pkg::SSM_MASTER_RX) ||
                          (mode == ssm_pkg::SSM_MASTER_IDLE);
      wake_reg   <= (receive_flag && receive_irq_enable_reg) ||
                    (transmit_flag && transmit_irq_enable_reg &&
                     peripheral_irq_enable_reg);
      vector_reg <= global_irq_enable_reg &&
                    ((receive_flag && receive_irq_enable_reg) ||
                     (transmit_flag && transmit_irq_enable_reg &&
                      peripheral_irq_enable_reg));
    end
  end

  assign s_axi_awready  = awready_reg;
  assign s_axi_wready   = wready_reg;
  assign s_axi_bvalid   = bvalid_reg;
  assign s_axi_bresp    = bresp_reg;
  assign s_axi_arready  = arready_reg;
  assign s_axi_rvalid   = rvalid_reg;
  assign s_axi_rdata    = rdata_reg;
  assign s_axi_rresp    = rresp_reg;
  assign clock_pin_o    = clock_pin_reg.o;
  assign clock_pin_oe   = clock_pin_reg.oe;
  assign data_pin_o     = data_pin_reg.o;
  assign data_pin_oe    = data_pin_reg.oe;
  assign processor_wake = wake_reg;
  assign irq_vector_req = vector_reg;
endmodule

// *** sim/ssm_top_asserts.sv ***
// checker for bus handshakes and pin and wake relations at the top ports
`timescale 1ns/1ps
module ssm_top_asserts (
  input logic        aclk, aresetn,
  input logic        s_axi_awvalid, s_axi_awready,
  input logic        s_axi_wvalid, s_axi_wready,
  input logic        s_axi_bvalid, s_axi_bready,
  input logic        s_axi_arvalid, s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid, s_axi_rready,
  input logic        clock_pin_oe, data_pin_oe,
  input logic        processor_wake, irq_vector_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rdata_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("rdata high");
  a_vector_needs_wake: assert property (
    irq_vector_req |-> processor_wake) else $error("vector without wake");
  a_one_pin_driver: assert property (
    !(clock_pin_oe && data_pin_oe)) else $error("both pins driven");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("no bvalid");
  a_write_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b dropped");
  a_no_aw_while_b: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("aw open");
  c_wake: cover property ($rose(processor_wake));
  c_tx_drive: cover property (data_pin_oe);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind ssm_top ssm_top_asserts i_chk (.*);

// *** sim/ssm_link_model.sv ***
// behavioural link partner: clocks the slave, or follows a device clock
`timescale 1ns/1ps
module ssm_link_model (
  output logic      ck,
  output logic      dt,
  input  wire logic cin,
  input  wire logic din
);
  initial ck = 1'h0;
  initial dt = 1'h0;
  // clock stands low between frames
  task automatic xfer(input logic [8:0] d, output logic [8:0] q,
                      input int bits = 8);
    q = 9'h000;
    for (int i = 0; i < bits; i++)
    begin
      ck = 1'h1;
      dt = d[i];
      #62.5 ck = 1'h0;
      q[i] = din;
      #62.5;
    end
    dt = ~dt; // released line must not keep the last bit
  endtask
  // follows a device-driven clock; bounded so a dead clock cannot hang
  task automatic serve(input logic [8:0] d, input int bits,
                       input logic pol);
    for (int i = 0; i < bits; i++)
    begin
      for (int n = 0; n < 4000 && cin !== pol; n++)
        #1;
      for (int n = 0; n < 4000 && cin === pol; n++)
        #1;
      dt = d[i];
    end
  endtask
endmodule

// *** sim/ssm_top_tb.sv ***
// bench: registers, slave receive, overrun, slave transmit, master receive
`timescale 1ns/1ps
module ssm_top_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, cpu_sleep;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, mck, mdt;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, clock_pin_o, clock_pin_oe;
  logic data_pin_o, data_pin_oe, processor_wake, irq_vector_req;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [8:0]  q;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire         clock_pin_i = clock_pin_oe ? clock_pin_o : mck;
  wire         data_pin_i = data_pin_oe ? data_pin_o : mdt;
  int          error_cnt, check_count;
  ssm_top i_dut (.*);
  ssm_link_model i_link (.ck(mck), .dt(mdt), .cin(clock_pin_i),
                         .din(data_pin_i));
  initial
  begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
      $display("BAD %0t got %h want %h", $time, got, exp);
    if (got !== exp)
      error_cnt++;
  endtask
  task automatic step(inout int n);
    @(posedge aclk);
    n++;
    if (n > 3000)
      error_cnt++;
    if (n > 3000)
      wrap_up();
  endtask
  task automatic await(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v)
      step(n);
  endtask
  task automatic wr(input logic [7:0] a, d, input logic [1:0] e = 2'h0);
    int n;
    logic aw_on;
    logic w_on;
    n = 0;
    aw_on = 1'h1;
    w_on = 1'h1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    // each channel is released at the edge that takes it
    do
    begin
      step(n);
      if (s_axi_awready)
        aw_on = 1'h0;
      if (s_axi_wready)
        w_on = 1'h0;
      s_axi_awvalid <= aw_on;
      s_axi_wvalid <= w_on;
    end
    while (aw_on || w_on);
    do step(n); while (s_axi_bvalid !== 1'h1);
    chk({30'h0, s_axi_bresp}, {30'h0, e});
  endtask
  task automatic rd(input logic [7:0] a, d, input logic [1:0] e = 2'h0);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do step(n); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do step(n); while (s_axi_rvalid !== 1'h1);
    chk(s_axi_rdata, {24'h0, d});
    chk({30'h0, s_axi_rresp}, {30'h0, e});
  endtask
  task automatic t_regs;
    rd(8'h18, 8'h00);
    rd(8'h20, 8'h00, 2'h2);
    wr(8'h20, 8'hFF, 2'h2);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h18);
    wr(8'h10, 8'h00);
    wr(8'h04, 8'hFF);
    rd(8'h04, 8'hF0);
    rd(8'h0C, 8'h00);
  endtask
  task automatic t_rx;
    wr(8'h00, 8'h10);
    wr(8'h04, 8'h90);
    wr(8'h1C, 8'h09);
    cpu_sleep <= 1'h1;
    i_link.xfer(9'h0A5, q);
    await(processor_wake, 1'h1);
    chk({31'h0, irq_vector_req}, 32'h1);
    rd(8'h04, 8'h90);
    rd(8'h08, 8'hA5);
    await(processor_wake, 1'h0);
  endtask
  task automatic t_ovr;
    i_link.xfer(9'h011, q);
    i_link.xfer(9'h022, q);
    i_link.xfer(9'h033, q);
    rd(8'h04, 8'h92);
    rd(8'h08, 8'h11);
    wr(8'h04, 8'h80);
    rd(8'h04, 8'h80);
    rd(8'h08, 8'h22);
  endtask
  task automatic t_tx;
    wr(8'h00, 8'h30);
    wr(8'h1C, 8'h06);
    wr(8'h0C, 8'h3C);
    wr(8'h0C, 8'hC3);
    rd(8'h1C, 8'h06);
    i_link.xfer(9'h000, q);
    chk({23'h0, q}, 32'h3C);
    await(processor_wake, 1'h1);
    chk({31'h0, irq_vector_req}, 32'h0);
    wr(8'h0C, 8'h5A);
    await(processor_wake, 1'h0);
    i_link.xfer(9'h000, q);
    chk({23'h0, q}, 32'hC3);
  endtask
  task automatic t_tx9;
    i_link.xfer(9'h000, q);
    chk({23'h0, q}, 32'h5A);
    wr(8'h00, 8'h71);
    wr(8'h0C, 8'h96);
    i_link.xfer(9'h000, q, 9);
    chk({23'h0, q}, 32'h196);
  endtask
  task automatic t_mrx;
    cpu_sleep <= 1'h0;
    wr(8'h10, 8'h10);
    wr(8'h04, 8'h80);
    wr(8'h14, 8'h04);
    wr(8'h00, 8'h90);
    wr(8'h1C, 8'h01);
    chk({31'h0, clock_pin_oe}, 32'h1);
    chk({31'h0, clock_pin_o}, 32'h1);
    fork
      i_link.serve(9'h1A5, 9, 1'h1);
      wr(8'h04, 8'hE0);
    join
    await(processor_wake, 1'h1);
    rd(8'h04, 8'hC1);
    rd(8'h08, 8'hA5);
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    {aresetn, cpu_sleep, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'h1;
    s_axi_rready = 1'h1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_rx();
    t_ovr();
    t_tx();
    t_tx9();
    t_mrx();
    wrap_up();
  end
endmodule
